// >>> src/sem_consts.svh
/*
 * Shared constants of the serial memory slave: timing, array geometry,
 * instruction codes and status bit positions.
 * Assumes it is included by the package and the modules by bare name.
 */
`ifndef SEM_CONSTS_SVH
`define SEM_CONSTS_SVH

// Clock period of clock_i and programming time
`define SEM_CLK_NS      40
`define SEM_T_WRITE_NS  5000000

// Array geometry
`define SEM_BYTES       512
`define SEM_PAGE_BYTES  16

// Instruction codes, low three bits, upper nibble zero
`define SEM_OP_WRSR     3'h1
`define SEM_OP_WRITE    3'h2
`define SEM_OP_READ     3'h3
`define SEM_OP_WRDI     3'h4
`define SEM_OP_RDSR     3'h5
`define SEM_OP_WREN     3'h6

// Status byte layout
`define SEM_SR_BUSY     0
`define SEM_SR_WEN      1
`define SEM_SR_BP0      2
`define SEM_SR_HWPE     7

// Block protect boundaries
`define SEM_BP_QUARTER  9'h180
`define SEM_BP_HALF     9'h100

`endif

// >>> src/sem_pkg.sv
/*
 * Types of the serial memory slave.
 * Assumes sem_consts.svh is on the include path.
 */
`include "sem_consts.svh"

package sem_pkg;

  // Serial sequence states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_CMD    = 7'h02,
    ST_ADDR   = 7'h04,
    ST_WDATA  = 7'h08,
    ST_SRDATA = 7'h10,
    ST_OUT    = 7'h20,
    ST_IGNORE = 7'h40
  } sem_state_t;

endpackage : sem_pkg

// >>> src/sem_sync.sv
/*
 * Two-flop synchroniser for a group of pins, with a third stage kept
 * as the previous value for edge detection.
 * Assumes inputs are asynchronous to clk_i.
 */
`timescale 1ns/100ps
`default_nettype none

module sem_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0   // Idle level of each pin
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Pins and synchronised copies
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] sync_o,
  output logic      [W-1:0] prev_o
);

  initial begin
    if (W < 1) $error("sem_sync: W must be at least 1");
  end

  typedef struct packed {
    logic [W-1:0] s1;   // First stage, read only by s2
    logic [W-1:0] s2;   // Settled value
    logic [W-1:0] p;    // Value one cycle older
  } sem_sync_t;

  sem_sync_t q, d;

  // Shift the pins along the chain
  always_comb begin
    d    = q;
    d.s1 = pin_i;
    d.s2 = q.s1;
    d.p  = q.s2;
  end

  // Register the chain; reset to idle levels so no false edge follows
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= {RST, RST, RST};
    end else begin
      q <= d;
    end
  end

  assign sync_o = q.s2;
  assign prev_o = q.p;

endmodule : sem_sync

`default_nettype wire

// >>> src/sem_array.sv
/*
 * Byte array in flip-flops with a masked whole-page write port and an
 * unregistered byte read port.
 * Assumes a write never lands in the same cycle as a read that matters.
 */
`timescale 1ns/100ps
`default_nettype none
`include "sem_consts.svh"

module sem_array #(
  parameter int BYTES = `SEM_BYTES,
  parameter int PAGE  = `SEM_PAGE_BYTES
) (
  // Clock
  input  wire logic                          clk_i,
  // Page write port
  input  wire logic                          we_i,
  input  wire logic [$clog2(BYTES/PAGE)-1:0] page_i,
  input  wire logic [PAGE-1:0][7:0]          data_i,
  input  wire logic [PAGE-1:0]               mask_i,
  // Byte read port
  input  wire logic [$clog2(BYTES)-1:0]      raddr_i,
  output logic      [7:0]                    rdata_o
);

  initial begin
    if (BYTES % PAGE != 0) $error("sem_array: BYTES not whole pages");
  end

  typedef struct packed {
    logic [BYTES-1:0][7:0] arr;   // Stored bytes, no reset
  } sem_array_t;

  sem_array_t q, d;

  // Program every masked byte of the addressed page at once
  always_comb begin
    d = q;
    for (int i = 0; i < PAGE; i++) begin
      if (we_i && mask_i[i]) begin
        d.arr[{page_i, i[$clog2(PAGE)-1:0]}] = data_i[i];
      end
    end
  end

  // Contents survive reset, like the cells they model
  always_ff @(posedge clk_i) begin
    q <= d;
  end

  assign rdata_o = q.arr[raddr_i];

endmodule : sem_array

`default_nettype wire

// >>> src/sem_slave.sv
/*
 * Serial peripheral slave of a 512 byte paged memory: instruction decode,
 * page buffer, self-timed programming, block protection and suspend.
 * Assumes the serial pins come from an outside master and are sampled
 * here by clock_i, which runs much faster than the serial clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "sem_consts.svh"

module sem_slave #(
  parameter int WRITE_CYCLES = `SEM_T_WRITE_NS / `SEM_CLK_NS
) (
  // Clock and power-on reset
  input  wire logic clock_i,
  input  wire logic rst_i,
  // Serial pins from the master
  input  wire logic sck_i,
  input  wire logic sel_n_i,
  input  wire logic si_i,
  input  wire logic suspend_n_i,
  input  wire logic protect_n_i,
  // Serial output pin
  output logic      so_o,
  output logic      so_oe_o
);

  localparam int TW = 17;   // Timer width

  initial begin
    if (WRITE_CYCLES < 1 || WRITE_CYCLES >= 2**TW)
      $error("sem_slave: WRITE_CYCLES out of range");
  end

  typedef struct packed {
    sem_pkg::sem_state_t st;      // Serial sequence state
    logic [2:0]          bitc;    // Bits taken in the current byte
    logic [7:0]          sh;      // Input shift register
    logic [7:0]          op;      // Instruction of this frame
    logic [8:0]          addr;    // Byte address
    logic [7:0]          tx;      // Output shift register
    logic [2:0]          obit;    // Bits sent of the current byte
    logic                so;      // Serial output level
    logic                so_oe;   // Serial output drive
    logic                wen;     // Write enable latch
    logic [1:0]          bp;      // Block protect level
    logic                hwpe;    // hw_protect_enable
    logic                busy;    // Programming in progress
    logic [TW-1:0]       timer;   // Programming cycles left
    logic [15:0][7:0]    page;    // Page buffer
    logic [15:0]         mask;    // Bytes loaded in the buffer
    logic [7:0]          srb;     // Status byte received
    logic                sr_ok;   // Status byte complete
    logic                mem_we;  // Page write strobe
  } sem_slave_t;

  sem_slave_t q, d;

  // Synchronised pins: sck, select, data, suspend, protect
  logic [4:0] pin_s;
  logic [4:0] pin_p;
  logic [7:0] rdata;

  // Idle levels: sck low, select high, data low, suspend high, protect high
  sem_sync #(
    .W   (5),
    .RST (5'h0b)
  ) u_sync (
    .clk_i  (clock_i),
    .rst_i  (rst_i),
    .pin_i  ({sck_i, sel_n_i, si_i, suspend_n_i, protect_n_i}),
    .sync_o (pin_s),
    .prev_o (pin_p)
  );

  sem_array u_array (
    .clk_i   (clock_i),
    .we_i    (q.mem_we),
    .page_i  (q.addr[8:4]),
    .data_i  (q.page),
    .mask_i  (q.mask),
    .raddr_i (q.addr),
    .rdata_o (rdata)
  );

  // Named views of the synchronised pins
  logic sck_s, sel_s, si_s, sus_s, wp_s;
  logic sck_rise, sck_fall, sel_rise, sel_fall, live;
  logic [7:0] inb;
  logic [7:0] status;

  assign sck_s    = pin_s[4];
  assign sel_s    = pin_s[3];
  assign si_s     = pin_s[2];
  assign sus_s    = pin_s[1];
  assign wp_s     = pin_s[0];
  assign sck_rise = sck_s & ~pin_p[4];
  assign sck_fall = ~sck_s & pin_p[4];
  assign sel_rise = sel_s & ~pin_p[3];
  assign sel_fall = ~sel_s & pin_p[3];
  // Serial edges count only while selected and not suspended
  assign live     = ~sel_s & sus_s;
  // Byte completed by this rising edge, MSB arrived first
  assign inb      = {q.sh[6:0], si_s};
  // Status byte reads all ones while programming
  always_comb begin
    status                = 8'h00;
    status[`SEM_SR_WEN]   = q.wen;
    status[`SEM_SR_BP0+:2] = q.bp;
    status[`SEM_SR_HWPE]  = q.hwpe;
    if (q.busy) status = 8'hff;
  end

  // True when the page at addr lies in the protected block
  function automatic logic prot(input logic [1:0] bp,
                                input logic [8:0] a);
    unique case (bp)
      2'h0:    prot = 1'b0;
      2'h1:    prot = (a >= `SEM_BP_QUARTER);
      2'h2:    prot = (a >= `SEM_BP_HALF);
      default: prot = 1'b1;
    endcase
  endfunction : prot

  // Next state of the whole slave
  always_comb begin
    d        = q;
    d.mem_we = 1'b0;
    // Self-timed programming needs no serial clock
    if (q.busy) begin
      if (q.timer == '0) begin
        d.busy = 1'b0;
      end else begin
        d.timer = q.timer - 1'b1;
      end
    end
    if (sel_rise) begin
      // End of frame: release output, launch any write
      d.st    = sem_pkg::ST_IDLE;
      d.so_oe = 1'b0;
      if (q.st == sem_pkg::ST_WDATA && q.mask != '0 && q.wen
          && !prot(q.bp, q.addr)) begin
        d.mem_we = 1'b1;
        d.busy   = 1'b1;
        d.timer  = TW'(WRITE_CYCLES - 1);
        d.wen    = 1'b0;
      end else if (q.sr_ok && q.wen) begin
        d.wen   = 1'b0;
        d.busy  = 1'b1;
        d.timer = TW'(WRITE_CYCLES - 1);
        if (!(!wp_s && q.hwpe)) begin
          d.bp   = q.srb[`SEM_SR_BP0+:2];
          d.hwpe = q.srb[`SEM_SR_HWPE];
        end
      end
    end else if (sel_s) begin
      d.st    = sem_pkg::ST_IDLE;
      d.so_oe = 1'b0;
    end else if (sel_fall) begin
      // New frame, first byte is the instruction
      d.st    = sem_pkg::ST_CMD;
      d.bitc  = 3'h0;
      d.sr_ok = 1'b0;
      d.mask  = '0;
    end else if (!sus_s) begin
      d.so_oe = 1'b0;
    end else if (live && sck_rise) begin
      d.sh   = inb;
      d.bitc = q.bitc + 3'h1;
      if (q.bitc == 3'h7) begin
        unique case (q.st)
          sem_pkg::ST_CMD: begin
            d.op = inb;
            d.st = sem_pkg::ST_IGNORE;
            if (inb[7:4] == 4'h0 && !(q.busy
                && inb[2:0] != `SEM_OP_RDSR)) begin
              unique case (inb[2:0])
                `SEM_OP_WREN: d.wen = 1'b1;
                `SEM_OP_WRDI: d.wen = 1'b0;
                `SEM_OP_RDSR: begin
                  d.st   = sem_pkg::ST_OUT;
                  d.obit = 3'h0;
                end
                `SEM_OP_WRSR: d.st = sem_pkg::ST_SRDATA;
                `SEM_OP_READ, `SEM_OP_WRITE: begin
                  d.addr[8] = inb[3];
                  d.st      = sem_pkg::ST_ADDR;
                end
                default: d.st = sem_pkg::ST_IGNORE;
              endcase
            end
          end
          sem_pkg::ST_ADDR: begin
            d.addr[7:0] = inb;
            d.obit      = 3'h0;
            d.st        = (q.op[2:0] == `SEM_OP_READ)
                          ? sem_pkg::ST_OUT : sem_pkg::ST_WDATA;
          end
          sem_pkg::ST_WDATA: begin
            // Fill the buffer, wrapping inside the page
            d.page[q.addr[3:0]] = inb;
            d.mask[q.addr[3:0]] = 1'b1;
            d.addr[3:0]         = q.addr[3:0] + 4'h1;
          end
          sem_pkg::ST_SRDATA: begin
            d.srb   = inb;
            d.sr_ok = 1'b1;
            d.st    = sem_pkg::ST_IGNORE;
          end
          default: ;
        endcase
      end
    end else if (live && sck_fall && q.st == sem_pkg::ST_OUT) begin
      // Shift out on the falling edge, reload each byte
      d.so_oe = 1'b1;
      d.obit  = q.obit + 3'h1;
      if (q.obit == 3'h0) begin
        d.so = (q.op[2:0] == `SEM_OP_READ) ? rdata[7] : status[7];
        d.tx = ((q.op[2:0] == `SEM_OP_READ) ? rdata : status) << 1;
      end else begin
        d.so = q.tx[7];
        d.tx = q.tx << 1;
      end
      if (q.obit == 3'h7 && q.op[2:0] == `SEM_OP_READ) begin
        d.addr = q.addr + 9'h001;
      end
    end
  end

  // Power-on reset puts everything in standby
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      q    <= '0;
      q.st <= sem_pkg::ST_IDLE;
    end else begin
      q <= d;
    end
  end

  assign so_o    = q.so;
  assign so_oe_o = q.so_oe;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  so_release_a: assert property (sel_s |=> !so_oe_o)
    else $error("output driven while deselected");
  rst_idle_a: assert property (disable iff (1'b0)
    rst_i |=> q.st == sem_pkg::ST_IDLE && !so_oe_o)
    else $error("reset did not restore standby");
  hold_pause_a: assert property (!sus_s && !sel_s && !pin_p[3]
    |=> $stable(q.bitc) && !so_oe_o)
    else $error("sequence moved while suspended");
  msb_first_a: assert property (live && sck_rise && !sel_fall
    && q.st == sem_pkg::ST_CMD && q.bitc == 3'h7
    |=> q.op == $past(inb))
    else $error("instruction not taken MSB first");
  busy_time_a: assert property ($rose(q.busy)
    |-> q.timer == TW'(WRITE_CYCLES - 1) && !q.wen)
    else $error("programming not started correctly");
  prot_block_a: assert property (q.mem_we
    |-> !prot(q.bp, q.addr) && $past(sel_rise))
    else $error("write into protected block");
  out_fall_a: assert property ($changed(q.so) && !$past(rst_i)
    |-> $past(sck_fall))
    else $error("output changed off a falling edge");
  page_wrap_a: assert property (q.st == sem_pkg::ST_WDATA
    && $past(q.st == sem_pkg::ST_WDATA)
    |-> q.addr[8:4] == $past(q.addr[8:4]))
    else $error("page write left its page");
  wp_lock_a: assert property (!wp_s && q.hwpe && !$past(rst_i)
    |=> $stable(q.bp) && q.hwpe)
    else $error("protect bits changed while locked");

  read_c:  cover property (q.st == sem_pkg::ST_OUT
    && q.op[2:0] == `SEM_OP_READ && sck_fall);
  write_c: cover property (q.mem_we);
  rdsr_c:  cover property (q.busy && q.st == sem_pkg::ST_OUT);

endmodule : sem_slave

`default_nettype wire

// >>> dv/sem_master.sv
/*
 * Serial master model for the memory slave: frames, bits, suspend.
 * Assumes clock_i is the slave clock; sck half period is 4 clocks.
 */
`timescale 1ns/100ps
`default_nettype none

module sem_master (
  // Clock
  input  wire logic clock_i,
  // Pins to the slave
  output var  logic sck_o,
  output var  logic sel_n_o,
  output var  logic si_o,
  output var  logic susp_n_o,
  // Pins from the slave
  input  wire logic so_i,
  input  wire logic so_oe_i
);
  logic cpol; // Idle clock level of this frame
  logic last; // Last value the slave drove

  // Pins idle at time zero
  initial begin
    cpol     = 1'b0;
    last     = 1'b0;
    sck_o    = 1'b0;
    sel_n_o  = 1'b1;
    si_o     = 1'b0;
    susp_n_o = 1'b1;
  end

  // Track the driven level of the data line
  always @(posedge clock_i) begin
    if (so_oe_i) begin
      last <= so_i;
    end
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clock_i);
  endtask : wt

  // Select falls with sck at its idle level
  task automatic start(input logic pol);
    @(posedge clock_i);
    cpol = pol;
    sck_o <= pol;
    wt(4);
    sel_n_o <= 1'b0;
    wt(4);
  endtask : start

  // Pause with sck low, clock garbage meanwhile, resume
  task automatic pause(input logic tx);
    wt(4);
    susp_n_o <= 1'b0;
    repeat (3) begin
      wt(4);
      sck_o <= 1'b1;
      si_o  <= ~tx;
      wt(4);
      sck_o <= 1'b0;
    end
    wt(4);
    susp_n_o <= 1'b1;
    si_o     <= tx;
  endtask : pause

  // One bit: fall with new data, rise, sample the line
  task automatic xbit(input logic tx, input logic hold, output logic rx);
    @(posedge clock_i);
    sck_o <= 1'b0;
    si_o  <= tx;
    if (hold) begin
      pause(tx);
    end
    wt(4);
    sck_o <= 1'b1;
    @(negedge clock_i);
    rx = so_oe_i ? so_i : ~last; // Released line is not trusted
    wt(3);
  endtask : xbit

  // One byte, most significant bit first; h picks a bit to pause at
  task automatic xbyte(input logic [7:0] tx, input int h,
                       output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      xbit(tx[i], i == h, rx[i]);
    end
  endtask : xbyte

  // Clock back to idle, then select rises
  task automatic stop();
    @(posedge clock_i);
    sck_o <= cpol;
    wt(4);
    sel_n_o <= 1'b1;
    wt(8);
  endtask : stop
endmodule : sem_master

`default_nettype wire

// >>> dv/tb_top.sv
/*
 * Self-checking bench of the serial memory slave with a byte model.
 * Assumes sem_master.sv and the design sources are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  localparam int WCYC = 400; // Short programming time

  logic        clock_i;   // 25 MHz clock
  logic        rst_i;     // Power-on reset
  logic        prot_n;    // Protect pin
  logic [31:0] rs;        // Random state
  logic [7:0]  st;        // Expected status byte
  logic [7:0]  mem [512]; // Model of the array
  bit          known [512];
  int          bad_count;
  int          n_checks;
  wire         sck, sel_n, si, susp_n, so, so_oe;

  // Clock
  always #20 clock_i = ~clock_i;

  sem_slave #(.WRITE_CYCLES(WCYC)) DUT (
    .clock_i(clock_i), .rst_i(rst_i), .sck_i(sck), .sel_n_i(sel_n),
    .si_i(si), .suspend_n_i(susp_n), .protect_n_i(prot_n),
    .so_o(so), .so_oe_o(so_oe));

  sem_master m (
    .clock_i(clock_i), .sck_o(sck), .sel_n_o(sel_n), .si_o(si),
    .susp_n_o(susp_n), .so_i(so), .so_oe_i(so_oe));

  function automatic logic [7:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[7:0];
  endfunction : rnd

  // Protected by the expected block protect level
  function automatic logic prot(input logic [8:0] p);
    return (st[3:2] == 2'h3) || (st[3:2] == 2'h2 && p[8]) ||
           (st[3:2] == 2'h1 && p[8:7] == 2'h3);
  endfunction : prot

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
      bad_count++;
    end
  endtask : check

  task automatic give_verdict();
    if (bad_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // Frame start in a random mode
  task automatic fs();
    logic [7:0] r;
    r = rnd();
    m.start(r[0]);
  endtask : fs

  task automatic op1(input logic [7:0] op);
    logic [7:0] d;
    fs();
    m.xbyte(op, -1, d);
    m.stop();
  endtask : op1

  task automatic rdsr(output logic [7:0] v);
    fs();
    m.xbyte(8'h05, -1, v);
    m.xbyte(8'h00, -1, v);
    m.stop();
  endtask : rdsr

  // Busy first, then the expected status within a few frames
  task automatic wait_ready();
    logic [7:0] v;
    int         n;
    n = 0;
    rdsr(v);
    check(v, 8'hff);
    while (v === 8'hff && n < 4) begin
      rdsr(v);
      n++;
    end
    check(v, st);
  endtask : wait_ready

  task automatic wrsr(input logic [7:0] v);
    logic [7:0] d;
    op1(8'h06);
    fs();
    m.xbyte(8'h01, -1, d);
    m.xbyte(v, -1, d);
    m.stop();
    wait_ready();
  endtask : wrsr

  task automatic wr(input logic [8:0] a, input int n);
    logic [7:0] d;
    logic [7:0] r;
    logic [8:0] p;
    logic [7:0] v;
    op1(8'h06);
    fs();
    m.xbyte({4'h0, a[8], 3'h2}, -1, r);
    m.xbyte(a[7:0], -1, r);
    for (int i = 0; i < n; i++) begin
      d = rnd();
      p = {a[8:4], a[3:0] + i[3:0]};
      if (!prot(p)) begin
        mem[p]   = d;
        known[p] = 1'b1;
      end
      m.xbyte(d, -1, r);
    end
    m.stop();
    // A refused write starts no busy cycle and keeps the latch set
    if (prot({a[8:4], 4'h0})) begin
      rdsr(v);
      check(v, st | 8'h02);
    end else begin
      wait_ready();
    end
  endtask : wr

  task automatic rd(input logic [8:0] a, input int n, input int h);
    logic [7:0] d;
    logic [8:0] p;
    fs();
    m.xbyte({4'h0, a[8], 3'h3}, -1, d);
    m.xbyte(a[7:0], h, d);
    for (int i = 0; i < n; i++) begin
      p = a + i[8:0];
      m.xbyte(8'h00, -1, d);
      if (known[p]) begin
        check(d, mem[p]);
      end
    end
    m.stop();
    check({7'h0, so_oe}, 8'h00);
  endtask : rd

  // Main sequence
  initial begin
    logic [7:0] v;
    logic       b;
    logic [8:0] pa [3];
    clock_i   = 1'b0;
    rst_i     = 1'b1;
    prot_n    = 1'b1;
    rs        = 32'h0000e51f;
    st        = 8'h00;
    bad_count = 0;
    n_checks  = 0;
    pa        = '{9'h0f3, 9'h17c, 9'h1f9};
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    m.wt(4);
    check({7'h0, so_oe}, 8'h00);
    rdsr(v);
    check(v, st);
    op1(8'h06);
    rdsr(v);
    check(v, 8'h02);
    op1(8'h04);
    rdsr(v);
    check(v, st);
    wr(9'h1f5, 18);
    wr(9'h000, 16);
    rd(9'h1f0, 32, 3);
    wr(9'h005, 1);
    rd(9'h000, 16, -1);
    for (int k = 0; k < 4; k++) begin
      st = {4'h0, k[1:0], 2'h0};
      wrsr(st);
      for (int j = 0; j < 3; j++) begin
        wr(pa[j], 1);
        rd(pa[j], 1, -1);
      end
    end
    st = 8'h80;
    wrsr(st);
    @(posedge clock_i);
    prot_n <= 1'b0;
    wrsr(8'h0c);
    @(posedge clock_i);
    prot_n <= 1'b1;
    st = 8'h8c;
    wrsr(st);
    fs();
    m.xbyte(8'h03, -1, v);
    m.xbyte(8'h40, -1, v);
    for (int i = 0; i < 3; i++) begin
      m.xbit(1'b0, 1'b0, b);
    end
    @(posedge clock_i);
    rst_i <= 1'b1;
    m.wt(3);
    @(negedge clock_i);
    check({7'h0, so_oe}, 8'h00);
    @(posedge clock_i);
    rst_i <= 1'b0;
    m.stop();
    st = 8'h00;
    rdsr(v);
    check(v, st);
    give_verdict();
  end
endmodule : tb_top

`default_nettype wire
